// File: core/ext_mem_pkg.sv
// Constants, register layouts and types for the external memory select block.
// Assumes a single processor clock domain; all offsets are data memory words.
package ext_mem_pkg;

	// Data memory map
	localparam logic [13:0] DM_REG_BASE      = 14'h3fe0; // 32 mapped control words
	localparam logic [13:0] DM_OVL_LIMIT     = 14'h1fff; // External data overlay window top
	localparam logic [13:0] PM_OVL_BASE      = 14'h2000; // External program overlay window
	localparam logic [13:0] SYS_CTRL_ADDR    = 14'h3fff;
	localparam logic [13:0] WAIT_CTRL_ADDR   = 14'h3ffe;
	localparam logic [13:0] COMP_CTRL_ADDR   = 14'h3fe6;

	// Overlay selector codes that reach external memory
	localparam logic [3:0]  OVL_EXT_LOW      = 4'h1;
	localparam logic [3:0]  OVL_EXT_HIGH     = 4'h2;

	// Address field layout
	localparam int          ADDR_W           = 14;
	localparam int          OVL_LSB_W        = 13;
	localparam int          IO_ADDR_W        = 11;
	localparam int          IO_REGION_LSB    = 9;
	localparam int          WAIT_W           = 3;

	// Wait state control register fields
	localparam int          WS_IO0_LSB       = 0;
	localparam int          WS_DATA_LSB      = 12;
	localparam int          WS_MODE_BIT      = 15;
	localparam logic [15:0] WAIT_CTRL_RESET  = 16'h7fff;
	localparam logic [15:0] WAIT_CTRL_MASK   = 16'hffff;

	// Composite control register fields (enable per select)
	localparam int          CS_PROG_BIT      = 0;
	localparam int          CS_DATA_BIT      = 1;
	localparam int          CS_BYTE_BIT      = 2;
	localparam int          CS_IO_BIT        = 3;
	localparam logic [15:0] COMP_CTRL_RESET  = 16'h000b;
	localparam logic [15:0] COMP_CTRL_MASK   = 16'h000f;

	// System control register fields
	localparam int          SC_PROG_WAIT_COUNT_LSB     = 0;
	localparam int          SC_BYTE_DIS_BIT  = 3;
	localparam int          SC_SPB_CFG_BIT   = 10;
	localparam int          SC_SPB_EN_BIT    = 11;
	localparam int          SC_SPA_EN_BIT    = 12;
	localparam logic [15:0] SYS_CTRL_RESET   = 16'h0807;
	localparam logic [15:0] SYS_CTRL_MASK    = 16'h1c0f;

	// Memory spaces the core can address
	typedef enum logic [1:0] {
		SPACE_PROG,
		SPACE_DATA,
		SPACE_IO,
		SPACE_BYTE
	} space_type;

	// One core access request
	typedef struct packed {
		space_type   space;
		logic        write;
		logic [13:0] addr;
		logic [15:0] wdata;
	} access_req_type;

	// Individual memory select levels, active high inside the block
	typedef struct packed {
		logic prog;
		logic data;
		logic byte_sel;
		logic io;
	} select_set_type;

endpackage

// File: core/ext_memory_select_and_wait_states.sv
// External memory select, overlay addressing and wait state generation.
// Assumes the core holds a request until done_o and issues one access at a time.
// Function
// - Program overlay 1/2 drives A13 low/high, low 13 bits from 0x2000-0x3fff.
// - Data overlay 1/2 drives A13 low/high, low 13 bits from 0x0000-0x1fff.
// - Internal data accesses take one cycle; external ones add data wait states.
// - Thirty-two data words at the top are memory-mapped control registers.
// - Host mode presents only A0 externally; internal memory stays fully usable.
// - I/O space has 2048 words, drives eleven address bits only.
// - I/O wait setting chosen per 512-word region, combined with mode bit.
// - Four three-bit I/O wait fields give up to 15 waits each.
// - Composite select follows every enabled individual select, same timing.
// - Composite enables reset to 1 except the byte select enable.
// - Composite select releases like other selects during granted bus request.
// - Serial port b configure bit picks alternate pins (0) or full port (1).
// - Byte select enabled after reset; software may disable and use composite.
`timescale 1ns/1ps

module ext_memory_select_and_wait_states #(
	parameter int WAIT_CNT_W = 4
) (
	// Clock, reset, enable
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          ce_i,
	// Core access port
	input  wire logic                          req_i,
	input  wire ext_mem_pkg::access_req_type   req_data_i,
	input  wire logic [3:0]                    prog_overlay_select_i,
	input  wire logic [3:0]                    data_overlay_select_i,
	input  wire logic                          host_mode_i,
	output logic                               done_o,
	output logic                               internal_o,
	output logic [15:0]                        rdata_o,
	// External bus arbitration
	input  wire logic                          bus_grant_i,
	// External memory pins
	output logic [13:0]                        ext_addr_o,
	output logic                               ext_write_o,
	output logic                               prog_space_select_n,
	output logic                               data_space_select_n,
	output logic                               byte_space_select_n,
	output logic                               io_space_select_n,
	output logic                               composite_select_n,
	output logic                               select_oe_o,
	// Serial port and pin configuration
	output logic                               serial_port_a_en_o,
	output logic                               serial_port_b_en_o,
	output logic                               serial_port_b_full_o
);
	import ext_mem_pkg::*;

	// Access timing overview
	// Cycle 0: request taken on the edge with req_i high and sequencer idle
	// Internal or register access: done_o high in cycle 1, nothing on the pins
	// External access: selects low from cycle 1 through cycle W+1
	// External access: done_o high in cycle W+2, selects back high then
	// Bus grant to another master pauses the count and lifts every select
	// Grant cycles add one cycle each to the done position
	// Register writes land on the taking edge, independent of bus grant
	// Register reads are captured on the taking edge into rdata_q
	// Unknown register words read as zero and ignore writes
	//
	// Wait state counting
	// Field value N from wait control, system control or the I/O region
	// Mode bit 0: exactly N waits
	// Mode bit 1: 2N+1 waits, except N of zero which stays zero
	// Three-bit fields therefore reach fifteen waits at most
	// Byte space accesses run with no waits in this block
	//
	// Address forming
	// Overlay accesses: A13 names the page, low bits come from the core address
	// I/O accesses: eleven address bits, upper three driven low
	// Upper I/O bits are undefined outside, so zero is a safe choice
	// Host mode: only A0 leaves the block, all other address pins held low
	// Wider host addressing needs latches outside the block
	//
	// Hazards and limits
	// The core must hold req_i and req_data_i stable until done_o
	// req_i still high after done_o is taken again as a new access
	// Overlay selectors are read live, so they must not move mid-access
	// Clock enable low freezes the sequencer and all register writes
	// Selects are combinational from registers and bus_grant_i; no glitch on one strobe source
	// Only one access is in flight; no queueing of requests

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXT,
		ST_DONE
	} state_type;

	state_type             state_q, state_d;
	logic [15:0]           wait_ctrl_q;
	logic [15:0]           comp_ctrl_q;
	logic [15:0]           sys_ctrl_q;
	logic [WAIT_CNT_W-1:0] wait_cnt_q, wait_cnt_d;
	logic [13:0]           ext_addr_q;
	logic                  ext_write_q;
	select_set_type        sel_q;
	logic                  internal_q;
	logic [15:0]           rdata_q;

	// Request classification
	wire logic prog_ovl_ext = (prog_overlay_select_i == OVL_EXT_LOW) ||
	                          (prog_overlay_select_i == OVL_EXT_HIGH);
	wire logic data_ovl_ext = (data_overlay_select_i == OVL_EXT_LOW) ||
	                          (data_overlay_select_i == OVL_EXT_HIGH);
	wire logic is_prog  = req_data_i.space == SPACE_PROG;
	wire logic is_data  = req_data_i.space == SPACE_DATA;
	wire logic is_io    = req_data_i.space == SPACE_IO;
	wire logic is_byte  = req_data_i.space == SPACE_BYTE;
	wire logic prog_ext = is_prog && prog_ovl_ext &&
	                      (req_data_i.addr >= PM_OVL_BASE);
	wire logic data_ext = is_data && data_ovl_ext &&
	                      (req_data_i.addr <= DM_OVL_LIMIT);
	wire logic reg_hit  = is_data && (req_data_i.addr >= DM_REG_BASE);
	wire logic goes_ext = prog_ext || data_ext || is_io || is_byte;

	// A13 of an overlay access tells the two external overlay pages apart
	wire logic [3:0] ovl_sel = is_prog ? prog_overlay_select_i : data_overlay_select_i;
	wire logic ovl_page_hi   = ovl_sel == OVL_EXT_HIGH;

	// External address forming; host mode only brings out A0
	wire logic [13:0] full_addr =
		is_io   ? {3'h0, req_data_i.addr[IO_ADDR_W-1:0]} :
		is_byte ? req_data_i.addr :
		          {ovl_page_hi, req_data_i.addr[OVL_LSB_W-1:0]};
	wire logic [13:0] pin_addr = host_mode_i ? {13'h0, full_addr[0]} : full_addr;

	// Wait field selection by space and I/O region
	wire logic [1:0] io_region = req_data_i.addr[IO_REGION_LSB+1:IO_REGION_LSB];
	wire logic [WAIT_W-1:0] io_wait =
		wait_ctrl_q[WS_IO0_LSB + WAIT_W*io_region +: WAIT_W];
	wire logic [WAIT_W-1:0] data_wait = wait_ctrl_q[WS_DATA_LSB +: WAIT_W];
	wire logic [WAIT_W-1:0] prog_wait = sys_ctrl_q[SC_PROG_WAIT_COUNT_LSB +: WAIT_W];
	wire logic [WAIT_W-1:0] wait_field =
		is_io   ? io_wait :
		is_data ? data_wait :
		is_prog ? prog_wait :
		          {WAIT_W{1'b0}};
	wire logic ws_mode = wait_ctrl_q[WS_MODE_BIT];

	// Zero stays zero; otherwise 2N+1 in mode 1, N in mode 0
	wire logic [WAIT_CNT_W-1:0] wait_n = WAIT_CNT_W'(wait_field);
	wire logic [WAIT_CNT_W-1:0] wait_states =
		(ws_mode && (wait_field != '0)) ? WAIT_CNT_W'({wait_n, 1'b1}) :
		                                  wait_n;

	// Register file decode
	wire logic wr_hit   = req_i && ce_i && (state_q == ST_IDLE) && reg_hit &&
	                      req_data_i.write;
	wire logic wr_wait  = wr_hit && (req_data_i.addr == WAIT_CTRL_ADDR);
	wire logic wr_comp  = wr_hit && (req_data_i.addr == COMP_CTRL_ADDR);
	wire logic wr_sys   = wr_hit && (req_data_i.addr == SYS_CTRL_ADDR);
	wire logic [15:0] reg_rdata =
		(req_data_i.addr == WAIT_CTRL_ADDR) ? wait_ctrl_q :
		(req_data_i.addr == COMP_CTRL_ADDR) ? comp_ctrl_q :
		(req_data_i.addr == SYS_CTRL_ADDR)  ? sys_ctrl_q :
		                                      16'h0000;

	// Reserved bits are masked; software should write them as zero
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wait_ctrl_q <= WAIT_CTRL_RESET;
			comp_ctrl_q <= COMP_CTRL_RESET;
			sys_ctrl_q  <= SYS_CTRL_RESET;
		end else begin
			if (wr_wait)
				wait_ctrl_q <= req_data_i.wdata & WAIT_CTRL_MASK;
			if (wr_comp)
				comp_ctrl_q <= req_data_i.wdata & COMP_CTRL_MASK;
			if (wr_sys)
				sys_ctrl_q  <= req_data_i.wdata & SYS_CTRL_MASK;
		end
	end

	// Sequencer states
	// Idle: waits for a request, loads the wait count for external ones
	// External: strobe phase, counts down while the bus is ours
	// Done: one-cycle completion pulse to the core, then back to idle
	//
	// Why a separate done state
	// Gives the core one clean cycle to drop its request
	// Keeps select release and done on the same edge for every space
	// Costs one cycle per access, accepted for simpler core handshake
	//
	// Count handling
	// Count loaded on the taking edge, so cycle 1 already strobes
	// Count of zero leaves after a single strobe cycle
	// Count frozen, not reloaded, across a granted bus request
	// Counter width comes from WAIT_CNT_W; four bits cover fifteen waits
	// A narrower counter would silently wrap long wait settings
	//
	// Composite select
	// Follows each enabled individual select through the shared strobe
	// Byte disable acts on the byte pin only, never on the composite path
	// Enables reset with byte off so boot uses the byte pin alone
	// Software sets the byte enable before disabling the byte pin
	//
	// Register access ordering
	// A write followed by an access that uses the new field is safe
	// The write lands before the next request can be taken
	// Reserved bits are masked on write and always read back as zero
	//
	// Serial port configuration bits are plain register outputs
	// Pin muxing for the alternate functions lives outside this block

	// Access sequencer: internal and register accesses finish in one cycle
	always_comb begin
		state_d    = state_q;
		wait_cnt_d = wait_cnt_q;
		case (state_q)
			ST_IDLE: begin
				if (req_i) begin
					if (goes_ext) begin
						state_d    = ST_EXT;
						wait_cnt_d = wait_states;
					end else begin
						state_d    = ST_DONE;
					end
				end
			end
			ST_EXT: begin
				// Hold off while another master owns the bus
				if (!bus_grant_i) begin
					if (wait_cnt_q == '0)
						state_d = ST_DONE;
					else
						wait_cnt_d = wait_cnt_q - 1'b1;
				end
			end
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Selects are captured once per access and held until the sequencer returns to idle
	wire select_set_type sel_next = '{
		prog:     prog_ext,
		data:     data_ext,
		byte_sel: is_byte,
		io:       is_io
	};

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_q     <= ST_IDLE;
			wait_cnt_q  <= '0;
			sel_q       <= '0;
			ext_addr_q  <= '0;
			ext_write_q <= 1'b0;
			internal_q  <= 1'b0;
			rdata_q     <= 16'h0000;
		end else if (ce_i) begin
			state_q    <= state_d;
			wait_cnt_q <= wait_cnt_d;
			if (state_q == ST_IDLE && req_i) begin
				sel_q       <= goes_ext ? sel_next : '0;
				ext_addr_q  <= goes_ext ? pin_addr : ext_addr_q;
				ext_write_q <= goes_ext && req_data_i.write;
				internal_q  <= !goes_ext;
				rdata_q     <= reg_hit ? reg_rdata : 16'h0000;
			end else if (state_d == ST_IDLE) begin
				sel_q       <= '0;
				ext_write_q <= 1'b0;
			end
		end
	end

	// Byte select can be suppressed; the composite path still sees it
	wire logic byte_dis  = sys_ctrl_q[SC_BYTE_DIS_BIT];
	wire logic strobe_on = (state_q == ST_EXT) && !bus_grant_i;
	wire logic comp_hit  =
		(sel_q.prog     && comp_ctrl_q[CS_PROG_BIT]) ||
		(sel_q.data     && comp_ctrl_q[CS_DATA_BIT]) ||
		(sel_q.byte_sel && comp_ctrl_q[CS_BYTE_BIT]) ||
		(sel_q.io       && comp_ctrl_q[CS_IO_BIT]);

	// Pin drive: all selects share one strobe so their timing matches
	assign prog_space_select_n = !(strobe_on && sel_q.prog);
	assign data_space_select_n = !(strobe_on && sel_q.data);
	assign io_space_select_n   = !(strobe_on && sel_q.io);
	assign byte_space_select_n = !(strobe_on && sel_q.byte_sel && !byte_dis);
	assign composite_select_n  = !(strobe_on && comp_hit);
	assign select_oe_o         = !bus_grant_i;
	assign ext_addr_o          = ext_addr_q;
	assign ext_write_o         = ext_write_q && strobe_on;

	// Core side results
	assign done_o     = state_q == ST_DONE;
	assign internal_o = internal_q;
	assign rdata_o    = rdata_q;

	// Serial port pin configuration from system control
	assign serial_port_a_en_o   = sys_ctrl_q[SC_SPA_EN_BIT];
	assign serial_port_b_en_o   = sys_ctrl_q[SC_SPB_EN_BIT];
	assign serial_port_b_full_o = sys_ctrl_q[SC_SPB_CFG_BIT];

endmodule

// File: verif/ext_mem_monitor.sv
// Checker on the select pins: address forming, strobe bounds, bus release.
// Assumes it is bound onto the block top and sees its ports only.
`timescale 1ns/1ps
module ext_mem_monitor (
	// Clock, reset and core side
	input wire logic ref_clk_i, rst_n_i, host_mode_i, bus_grant_i,
	input wire ext_mem_pkg::access_req_type req_data_i,
	input wire logic [3:0] prog_overlay_select_i, data_overlay_select_i,
	// Block outputs
	input wire logic done_o, select_oe_o, composite_select_n, prog_space_select_n,
	input wire logic data_space_select_n, byte_space_select_n, io_space_select_n,
	input wire logic [13:0] ext_addr_o
);
	import ext_mem_pkg::*;
	// Any select low marks a strobe
	wire all_hi = &{prog_space_select_n, data_space_select_n, byte_space_select_n,
		io_space_select_n, composite_select_n};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	grant_release_a: assert property (bus_grant_i |-> all_hi && !select_oe_o)
		else $error("selects held under grant");
	io_addr_a: assert property (!io_space_select_n |-> ext_addr_o[13:11] == 3'h0)
		else $error("io upper address driven");
	data_addr_a: assert property (!data_space_select_n && !host_mode_i |-> ext_addr_o ==
		{data_overlay_select_i == OVL_EXT_HIGH, req_data_i.addr[12:0]}) else $error("data addr");
	prog_addr_a: assert property (!prog_space_select_n && !host_mode_i |-> ext_addr_o ==
		{prog_overlay_select_i == OVL_EXT_HIGH, req_data_i.addr[12:0]}) else $error("prog addr");
	host_addr_a: assert property (host_mode_i && !all_hi |-> ext_addr_o[13:1] == 13'h0)
		else $error("host mode address wider than A0");
	end_done_a: assert property ($rose(all_hi) && select_oe_o |-> done_o)
		else $error("strobe end without done");
	wait_bound_a: assert property ($fell(all_hi) |-> ##[1:16] all_hi)
		else $error("strobe longer than fifteen waits");
	comp_source_a: assert property (!composite_select_n |-> req_data_i.space == SPACE_BYTE
		|| !(prog_space_select_n && data_space_select_n && io_space_select_n))
		else $error("composite without source");
endmodule
bind ext_memory_select_and_wait_states ext_mem_monitor u_mon (.ref_clk_i, .rst_n_i,
	.host_mode_i, .bus_grant_i, .req_data_i, .prog_overlay_select_i, .data_overlay_select_i,
	.done_o, .select_oe_o, .composite_select_n, .prog_space_select_n, .data_space_select_n,
	.byte_space_select_n, .io_space_select_n, .ext_addr_o);

// File: verif/ext_mem_model.sv
// Far side: memories and peripherals watching the select pins.
// Assumes pins come straight from the block; nothing is driven back.
`timescale 1ns/1ps
module ext_mem_model (
	// Pins from the block
	input  wire logic        ref_clk_i,
	input  wire logic [13:0] ext_addr_i,
	input  wire logic [4:0]  sel_n_i,
	input  wire logic        select_oe_i,
	// What was seen of the last access
	output logic [13:0]      seen_addr_o,
	output logic [4:0]       seen_sel_o,
	output logic [4:0]       seen_len_o = 5'h00
);
	// First strobe cycle latched; a grant pause keeps the count
	always @(posedge ref_clk_i) begin
		if (!(&sel_n_i)) begin
			seen_len_o <= seen_len_o + 5'h01;
			if (seen_len_o == 5'h00) begin
				seen_addr_o <= ext_addr_i;
				seen_sel_o  <= sel_n_i;
			end
		end else if (select_oe_i) begin
			seen_len_o <= 5'h00;
		end
	end
endmodule

// File: verif/tb_ext_memory_select_and_wait_states.sv
// Self-checking bench for the external memory select block.
// Assumes the package, the block, the model and the checker compile first.
`timescale 1ns/1ps
module tb_ext_memory_select_and_wait_states;
	import ext_mem_pkg::*;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, req_i = 1'b0, host = 1'b0, grant = 1'b0;
	logic [3:0] pov = 4'h0, dov = 4'h0;
	access_req_type rq = '0;
	wire logic done, intl, ewr, oe, spa, spb, spf, p_n, d_n, b_n, i_n, c_n;
	wire logic [15:0] rdata;
	wire logic [13:0] ea, s_addr;
	wire logic [4:0] s_sel, s_len;
	int miscompares = 0, total_checks = 0, n;
	int wr_cycles = 0;
	// Block under test, clock enable held on
	ext_memory_select_and_wait_states u_dut (.ref_clk_i, .rst_n_i, .ce_i(1'b1), .req_i,
		.req_data_i(rq), .prog_overlay_select_i(pov), .data_overlay_select_i(dov),
		.host_mode_i(host), .done_o(done), .internal_o(intl), .rdata_o(rdata),
		.bus_grant_i(grant), .ext_addr_o(ea), .ext_write_o(ewr), .prog_space_select_n(p_n),
		.data_space_select_n(d_n), .byte_space_select_n(b_n), .io_space_select_n(i_n),
		.composite_select_n(c_n), .select_oe_o(oe), .serial_port_a_en_o(spa),
		.serial_port_b_en_o(spb), .serial_port_b_full_o(spf));
	ext_mem_model mem (.ref_clk_i, .ext_addr_i(ea), .sel_n_i({p_n, d_n, b_n, i_n, c_n}),
		.select_oe_i(oe), .seen_addr_o(s_addr), .seen_sel_o(s_sel), .seen_len_o(s_len));
	// Clock at 100 MHz
	always #5 ref_clk_i = ~ref_clk_i;
	// Write strobe counted mid-cycle, away from the launching edge
	always @(negedge ref_clk_i) if (ewr === 1'b1) wr_cycles++;
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
		total_checks++;
		if (sn !== ex) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	// One access held until done; n counts cycles from the taking edge
	task automatic acc(input space_type sp, input logic [13:0] a,
		input logic [15:0] wd = 16'h0000, input logic wr = 1'b0);
		@(posedge ref_clk_i);
		#1 rq = '{sp, wr, a, wd};
		req_i = 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1 n++;
		end while (done !== 1'b1 && n < 80);
		req_i = 1'b0;
	endtask
	// External access judged at the far side; g is cycles lost to a grant
	task automatic xchk(input space_type sp, input logic [13:0] a, input logic [13:0] x,
		input logic [4:0] sel, input int w, input int g = 0);
		acc(sp, a);
		chk("ext address", {2'h0, x}, {2'h0, s_addr});
		chk("select set", {11'h0, sel}, {11'h0, s_sel});
		chk("strobe cycles", 16'(w + 1), {11'h0, s_len});
		chk("done cycle", 16'(w + 2 + g), n[15:0]);
	endtask
	task automatic rd(input logic [13:0] a, input logic [15:0] x);
		acc(SPACE_DATA, a);
		chk("read data", x, rdata);
		chk("internal one cycle", 16'h8001, {intl, n[14:0]});
	endtask
	task automatic t_reset();
		rd(WAIT_CTRL_ADDR, WAIT_CTRL_RESET);
		rd(COMP_CTRL_ADDR, 16'h000b);
		rd(SYS_CTRL_ADDR, 16'h0807);
		rd(14'h3fe1, 16'h0000);
		rd(14'h0100, 16'h0000);
		chk("serial ports", 16'h0002, {13'h0, spa, spb, spf});
	endtask
	// Both data overlays, overlay 1 at its window top, then host mode
	task automatic t_data();
		acc(SPACE_DATA, WAIT_CTRL_ADDR, 16'h28d1, 1'b1);
		dov = 4'h2;
		xchk(SPACE_DATA, 14'h1234, 14'h3234, 5'h16, 2);
		dov = 4'h1;
		xchk(SPACE_DATA, 14'h1fff, 14'h1fff, 5'h16, 2);
		host = 1'b1;
		xchk(SPACE_DATA, 14'h1235, 14'h0001, 5'h16, 2);
		host = 1'b0;
	endtask
	// Top word of every I/O region in both wait modes
	task automatic t_io();
		int w;
		for (int m = 0; m < 2; m++) begin
			acc(SPACE_DATA, WAIT_CTRL_ADDR, {m[0], 15'h28d1}, 1'b1);
			for (int r = 0; r < 4; r++) begin
				w = m ? 2 * r + 3 : r + 1;
				xchk(SPACE_IO, {3'h7, r[1:0], 9'h1ff}, {3'h0, r[1:0], 9'h1ff}, 5'h1c, w);
			end
		end
		// External write in mode 1, region 0 field 1: three waits, four strobe cycles
		wr_cycles = 0;
		acc(SPACE_IO, 14'h0005, 16'h5a5a, 1'b1);
		chk("write strobe cycles", 16'h0004, wr_cycles[15:0]);
	endtask
	task automatic t_prog();
		pov = 4'h1;
		xchk(SPACE_PROG, 14'h2abc, 14'h0abc, 5'h0e, 15);
		pov = 4'h2;
		xchk(SPACE_PROG, 14'h3fff, 14'h3fff, 5'h0e, 15);
		pov = 4'h0;
		acc(SPACE_PROG, 14'h2000);
		chk("internal prog", 16'h8001, {intl, n[14:0]});
	endtask
	// Bus granted away in mid access, then resumed
	task automatic t_grant();
		dov = 4'h2;
		fork
			xchk(SPACE_DATA, 14'h0042, 14'h2042, 5'h16, 5, 3);
			begin
				repeat (3) @(posedge ref_clk_i);
				#1 grant = 1'b1;
				repeat (3) @(posedge ref_clk_i);
				#1 grant = 1'b0;
			end
		join
	endtask
	// Boot select alone, then disabled with composite taking over
	task automatic t_byte();
		xchk(SPACE_BYTE, 14'h0123, 14'h0123, 5'h1b, 0);
		acc(SPACE_DATA, COMP_CTRL_ADDR, 16'h000f, 1'b1);
		acc(SPACE_DATA, SYS_CTRL_ADDR, 16'h1c0f, 1'b1);
		xchk(SPACE_BYTE, 14'h0321, 14'h0321, 5'h1e, 0);
		rd(SYS_CTRL_ADDR, 16'h1c0f);
		chk("serial ports", 16'h0007, {13'h0, spa, spb, spf});
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reset for four cycles, then the scenarios
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1 rst_n_i = 1'b1;
		t_reset();
		t_data();
		t_io();
		t_prog();
		t_grant();
		t_byte();
		test_done();
	end
	// Hang guard, far past the 160 or so cycles needed
	initial begin
		#50000 miscompares++;
		test_done();
	end
endmodule
